// ==== rtl/dpil_pkg.sv ====
// constants, types and states shared by the debug port instruction layer.
// assumes a byte-level uart phy that reports sync, break and bit-time ticks.
package dpil_pkg;
  // instruction byte: class in the top three bits
  localparam int OP_LSB = 5;
  localparam logic [2:0] OP_READ_IND = 3'h1;
  localparam logic [2:0] OP_WRITE_IND = 3'h3;
  localparam logic [2:0] OP_READ_CS = 3'h4;
  localparam logic [2:0] OP_REPEAT = 3'h5;
  localparam logic [2:0] OP_WRITE_CS = 3'h6;
  localparam logic [2:0] OP_KEY = 3'h7;
  // pointer mode field and size field
  localparam int PTR_LSB = 2;
  localparam logic [1:0] PTR_PLAIN = 2'h0;
  localparam logic [1:0] PTR_POSTINC = 2'h1;
  localparam logic [1:0] PTR_LOAD = 2'h2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam int SIB_FLAG_BIT = 2;
  localparam logic [4:0] KEY_BYTES = 5'h08;
  localparam logic [4:0] SIB_BYTES_LONG = 5'h10;
  localparam logic [7:0] ACK_CHAR = 8'h40;
  // control space
  localparam logic [3:0] CS_STATUS = 4'h0;
  localparam logic [3:0] CS_CTRL_A = 4'h2;
  localparam logic [3:0] CS_CTRL_B = 4'h3;
  localparam logic [7:0] CS_RESET = 8'h00;
  localparam int GT_LSB = 0;
  localparam logic [2:0] GT_NONE = 3'h7;
  localparam logic [7:0] GT_MAX_BITS = 8'h80;
  localparam int GAP_EN_BIT = 0;
  localparam logic [7:0] GAP_BITS = 8'h02;
  localparam int WB_IDX_LSB = 2;
  localparam int WB_MAP_BITS = 6;

  typedef enum logic [2:0] {
    ST_WAIT_SYNC, ST_INSTR, ST_RXOP, ST_BUSWR, ST_BUSRD, ST_TX
  } dpil_state_e;

  typedef struct packed {
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dpil_mem_req_s;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } dpil_tx_s;
endpackage

// ==== rtl/dpil_tx_pacer.sv ====
// transmit pacing: idle bits before each byte handed to the phy.
// assumes bit_tick_i pulses once per bit time at the current baud rate.
`timescale 1ns/1ps
module dpil_tx_pacer (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire dpil_pkg::dpil_tx_s req_i,
  output logic req_ready_o,
  input wire logic bit_tick_i,
  input wire logic [7:0] guard_bits_i,
  input wire logic gap_en_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i
);
  logic busy_q;
  logic [7:0] wait_q;
  logic [7:0] data_q;

  assign req_ready_o = !busy_q;
  assign tx_valid_o = busy_q && (wait_q == 8'h00);
  assign tx_data_o = data_q;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      wait_q <= 8'h00;
      data_q <= 8'h00;
    end else if (req_valid_i && !busy_q) begin
      busy_q <= 1'b1;
      data_q <= req_i.data;
      // turnaround byte waits guard only; gap never stacks on it
      wait_q <= req_i.first ? guard_bits_i : (gap_en_i ? dpil_pkg::GAP_BITS : 8'h00);
    end else if (busy_q && wait_q != 8'h00) begin
      if (bit_tick_i) begin
        wait_q <= wait_q - 8'h01;
      end
    end else if (tx_valid_o && tx_ready_i) begin
      busy_q <= 1'b0;
    end
  end
endmodule

// ==== rtl/dpil_cs_regs.sv ====
// 16-byte control/status space, reachable by the debugger and by wishbone.
// assumes a classic wishbone master holding each request until ack.
`timescale 1ns/1ps
module dpil_cs_regs #(
  parameter int AW = 8
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dbg_we_i,
  input wire logic [3:0] dbg_addr_i,
  input wire logic [7:0] dbg_wdata_i,
  output logic [7:0] dbg_rdata_o,
  input wire logic [7:0] status_i,
  output logic [2:0] guard_val_o,
  output logic gap_en_o
);
  logic [7:0] regs_q [16];
  logic ack_q;
  logic [31:0] dat_q;
  logic [3:0] wb_idx;
  logic wb_mapped;

  // index field and unmapped-range test both need six address bits
  if (AW < dpil_pkg::WB_MAP_BITS) begin
    $error("wishbone address too narrow");
  end

  function automatic logic [7:0] rd(input logic [3:0] a, input logic [7:0] st);
    rd = (a == dpil_pkg::CS_STATUS) ? st : regs_q[a];
  endfunction

  assign wb_idx = wb_adr_i[dpil_pkg::WB_IDX_LSB +: 4];
  assign wb_mapped = (wb_adr_i[AW-1:dpil_pkg::WB_MAP_BITS] == '0);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign dbg_rdata_o = rd(dbg_addr_i, status_i);
  assign guard_val_o = regs_q[dpil_pkg::CS_CTRL_A][dpil_pkg::GT_LSB +: 3];
  assign gap_en_o = regs_q[dpil_pkg::CS_CTRL_B][dpil_pkg::GAP_EN_BIT];

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      dat_q <= wb_mapped ? {24'h000000, rd(wb_idx, status_i)} : 32'h0000_0000;
    end
  end

  // debugger write wins over a bus write in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 16; i++) regs_q[i] <= dpil_pkg::CS_RESET;
    end else if (dbg_we_i && dbg_addr_i != dpil_pkg::CS_STATUS) begin
      regs_q[dbg_addr_i] <= dbg_wdata_i;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0] && wb_mapped
                 && wb_idx != dpil_pkg::CS_STATUS) begin
      regs_q[wb_idx] <= wb_dat_i[7:0];
    end
  end
endmodule

// ==== rtl/dpil_core.sv ====
// instruction layer of the one_wire_debug_port: decodes instruction frames,
// runs indirect bus access, control space access, repeat and key exchange.
// assumes a uart phy below (bytes, sync, break, bit ticks) and a bus
// that answers each request with a one-cycle ack.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

module dpil_core #(
  parameter int AW = 8,
  parameter logic [127:0] SIB_DATA = 128'h0123_4567_89AB_CDEF_0123_4567_89AB_CDEF
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic sync_i,
  input wire logic break_i,
  input wire logic bit_tick_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic mem_valid_o,
  output dpil_pkg::dpil_mem_req_s mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic [63:0] key_o,
  output logic key_valid_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  dpil_pkg::dpil_state_e state_q;
  logic [7:0] op_q;
  logic [4:0] cnt_q;
  logic [15:0] buf_q;
  logic [15:0] ptr_q;
  logic [7:0] rpt_q;
  logic [127:0] txb_q;
  logic turn_q;
  logic [63:0] key_q;
  logic key_valid_q;

  logic [7:0] cur_op;
  logic new_op;
  logic again;
  logic begin_op;
  logic last_rx;
  logic tx_take;
  logic finish;
  logic [15:0] operand;
  logic cs_we;
  logic [7:0] cs_rdata;
  logic [7:0] status;
  logic [2:0] guard_val;
  logic gap_en;
  logic pacer_ready;
  dpil_pkg::dpil_tx_s tx_req;

  function automatic logic [2:0] op_class(input logic [7:0] op);
    op_class = op[dpil_pkg::OP_LSB +: 3];
  endfunction

  function automatic logic [1:0] ptr_mode(input logic [7:0] op);
    ptr_mode = op[dpil_pkg::PTR_LSB +: 2];
  endfunction

  function automatic logic is_word(input logic [7:0] op);
    is_word = (op[1:0] == dpil_pkg::SIZE_WORD);
  endfunction

  // reserved widths, pointer modes and key sizes drop the instruction
  function automatic logic legal(input logic [7:0] op);
    logic sz_ok;
    sz_ok = (op[1:0] == dpil_pkg::SIZE_BYTE) || (op[1:0] == dpil_pkg::SIZE_WORD);
    unique case (op_class(op))
      dpil_pkg::OP_READ_IND: legal = sz_ok && (ptr_mode(op) <= dpil_pkg::PTR_LOAD);
      dpil_pkg::OP_WRITE_IND: legal = sz_ok && (ptr_mode(op) <= dpil_pkg::PTR_LOAD);
      dpil_pkg::OP_READ_CS: legal = 1'b1;
      dpil_pkg::OP_WRITE_CS: legal = 1'b1;
      dpil_pkg::OP_REPEAT: legal = (op[1:0] == dpil_pkg::SIZE_BYTE);
      // a key is only ever 64 bits; info block may be 8 or 16 bytes
      dpil_pkg::OP_KEY: legal = op[dpil_pkg::SIB_FLAG_BIT] ? sz_ok
                                : (op[1:0] == dpil_pkg::SIZE_BYTE);
      default: legal = 1'b0;
    endcase
  endfunction

  // bytes to receive or transmit for one pass of the instruction
  function automatic logic [4:0] op_len(input logic [7:0] op);
    unique case (op_class(op))
      dpil_pkg::OP_READ_IND: op_len = is_word(op) ? 5'h02 : 5'h01;
      dpil_pkg::OP_WRITE_IND: op_len = is_word(op) ? 5'h02 : 5'h01;
      dpil_pkg::OP_KEY: op_len = (op[dpil_pkg::SIB_FLAG_BIT] && is_word(op))
                                 ? dpil_pkg::SIB_BYTES_LONG : dpil_pkg::KEY_BYTES;
      default: op_len = 5'h01;
    endcase
  endfunction

  function automatic dpil_pkg::dpil_state_e op_entry(input logic [7:0] op);
    unique case (op_class(op))
      dpil_pkg::OP_READ_IND: op_entry = (ptr_mode(op) == dpil_pkg::PTR_LOAD)
                                        ? dpil_pkg::ST_TX : dpil_pkg::ST_BUSRD;
      dpil_pkg::OP_READ_CS: op_entry = dpil_pkg::ST_TX;
      dpil_pkg::OP_KEY: op_entry = op[dpil_pkg::SIB_FLAG_BIT]
                                   ? dpil_pkg::ST_TX : dpil_pkg::ST_RXOP;
      default: op_entry = dpil_pkg::ST_RXOP;
    endcase
  endfunction

  // code 7 means no idle bits; lower codes halve a long guard each step
  function automatic logic [7:0] guard_bits(input logic [2:0] gt);
    guard_bits = (gt == dpil_pkg::GT_NONE) ? 8'h00 : (dpil_pkg::GT_MAX_BITS >> gt);
  endfunction

  function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic [7:0] op);
    ptr_step = p + (is_word(op) ? 16'h0002 : 16'h0001);
  endfunction

  assign cur_op = (state_q == dpil_pkg::ST_INSTR) ? rx_data_i : op_q;
  assign new_op = (state_q == dpil_pkg::ST_INSTR) && rx_valid_i && legal(rx_data_i);
  assign last_rx = (state_q == dpil_pkg::ST_RXOP) && rx_valid_i && (cnt_q == 5'h01);
  assign tx_take = (state_q == dpil_pkg::ST_TX) && pacer_ready;
  // an instruction ends after its last output byte, or after its last
  // operand when it answers nothing (control store, repeat, key)
  assign finish = (tx_take && cnt_q == 5'h01)
                  || (last_rx && (op_class(op_q) == dpil_pkg::OP_WRITE_CS
                                  || op_class(op_q) == dpil_pkg::OP_REPEAT
                                  || op_class(op_q) == dpil_pkg::OP_KEY));
  // repeat passes restart straight at the instruction's entry state (op_entry), no sync, no opcode
  assign again = finish && rpt_q != 8'h00
                 && op_class(op_q) != dpil_pkg::OP_REPEAT;
  assign begin_op = new_op || again;
  assign operand = is_word(op_q) ? {rx_data_i, buf_q[15:8]} : {8'h00, rx_data_i};
  assign cs_we = last_rx && op_class(op_q) == dpil_pkg::OP_WRITE_CS;
  assign status = {5'h00, state_q == dpil_pkg::ST_TX, rpt_q != 8'h00,
                   state_q != dpil_pkg::ST_WAIT_SYNC};

  assign mem_valid_o = (state_q == dpil_pkg::ST_BUSWR) || (state_q == dpil_pkg::ST_BUSRD);
  assign mem_req_o.we = (state_q == dpil_pkg::ST_BUSWR);
  assign mem_req_o.word = is_word(op_q);
  assign mem_req_o.addr = ptr_q;
  assign mem_req_o.wdata = buf_q;
  assign key_o = key_q;
  assign key_valid_o = key_valid_q;

  assign tx_req.first = turn_q;
  assign tx_req.data = txb_q[7:0];

  // instruction sequencing
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= dpil_pkg::ST_WAIT_SYNC;
    end else if (break_i) begin
      state_q <= dpil_pkg::ST_WAIT_SYNC;
    end else begin
      unique case (state_q)
        dpil_pkg::ST_WAIT_SYNC: begin
          if (sync_i) begin
            state_q <= dpil_pkg::ST_INSTR;
          end
        end
        dpil_pkg::ST_INSTR: begin
          if (rx_valid_i) begin
            state_q <= legal(rx_data_i) ? op_entry(rx_data_i) : dpil_pkg::ST_WAIT_SYNC;
          end
        end
        dpil_pkg::ST_RXOP: begin
          if (last_rx) begin
            if (op_class(op_q) != dpil_pkg::OP_WRITE_IND) begin
              state_q <= again ? op_entry(op_q) : dpil_pkg::ST_WAIT_SYNC;
            end else if (ptr_mode(op_q) == dpil_pkg::PTR_LOAD) begin
              state_q <= dpil_pkg::ST_TX;
            end else begin
              state_q <= dpil_pkg::ST_BUSWR;
            end
          end
        end
        dpil_pkg::ST_BUSWR: begin
          if (mem_ack_i) begin
            state_q <= dpil_pkg::ST_TX;
          end
        end
        dpil_pkg::ST_BUSRD: begin
          if (mem_ack_i) begin
            state_q <= dpil_pkg::ST_TX;
          end
        end
        dpil_pkg::ST_TX: begin
          if (finish) begin
            state_q <= again ? op_entry(op_q) : dpil_pkg::ST_WAIT_SYNC;
          end
        end
      endcase
    end
  end

  // opcode and byte counter
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_q <= 8'h00;
      cnt_q <= 5'h00;
    end else begin
      if (new_op) begin
        op_q <= rx_data_i;
      end
      if (begin_op) begin
        cnt_q <= op_len(cur_op);
      end else if ((state_q == dpil_pkg::ST_BUSWR && mem_ack_i)
                   || (last_rx && op_class(op_q) == dpil_pkg::OP_WRITE_IND)) begin
        // acknowledge byte count; must beat the operand decrement below
        cnt_q <= 5'h01;
      end else if ((state_q == dpil_pkg::ST_RXOP && rx_valid_i) || tx_take) begin
        cnt_q <= cnt_q - 5'h01;
      end else if (state_q == dpil_pkg::ST_BUSRD && mem_ack_i) begin
        cnt_q <= op_len(op_q);
      end
    end
  end

  // operand assembly, least significant byte first
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      buf_q <= 16'h0000;
    end else if (state_q == dpil_pkg::ST_RXOP && rx_valid_i) begin
      buf_q <= last_rx ? operand : {rx_data_i, buf_q[15:8]};
    end
  end

  // address pointer
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_q <= 16'h0000;
    end else if (last_rx && op_class(op_q) == dpil_pkg::OP_WRITE_IND
                 && ptr_mode(op_q) == dpil_pkg::PTR_LOAD) begin
      ptr_q <= operand;
    end else if (mem_valid_o && mem_ack_i && ptr_mode(op_q) == dpil_pkg::PTR_POSTINC) begin
      // post-increment only once the access is done; plain mode keeps it
      ptr_q <= ptr_step(ptr_q, op_q);
    end
  end

  // repeat counter; a break or reset drops a pending count, and a new repeat operand replaces it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rpt_q <= 8'h00;
    end else if (break_i) begin
      rpt_q <= 8'h00;
    end else if (last_rx && op_class(op_q) == dpil_pkg::OP_REPEAT) begin
      rpt_q <= rx_data_i;
    end else if (again) begin
      rpt_q <= rpt_q - 8'h01;
    end
  end

  // transmit shift buffer
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      txb_q <= '0;
    end else if (begin_op && op_class(cur_op) == dpil_pkg::OP_READ_IND) begin
      txb_q <= {112'h0, ptr_q};
    end else if (begin_op && op_class(cur_op) == dpil_pkg::OP_READ_CS) begin
      txb_q <= {120'h0, cs_rdata};
    end else if (begin_op && op_class(cur_op) == dpil_pkg::OP_KEY) begin
      txb_q <= SIB_DATA;
    end else if ((state_q == dpil_pkg::ST_BUSWR && mem_ack_i)
                 || (last_rx && op_class(op_q) == dpil_pkg::OP_WRITE_IND)) begin
      txb_q <= {120'h0, dpil_pkg::ACK_CHAR};
    end else if (state_q == dpil_pkg::ST_BUSRD && mem_ack_i) begin
      txb_q <= {112'h0, mem_rdata_i};
    end else if (tx_take) begin
      txb_q <= {8'h00, txb_q[127:8]};
    end
  end

  // direction turnaround: any received byte makes the next output a first byte
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      turn_q <= 1'b1;
    end else if (rx_valid_i) begin
      turn_q <= 1'b1;
    end else if (tx_take) begin
      turn_q <= 1'b0;
    end
  end

  // key capture; no reply is queued for it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      key_q <= 64'h0;
      key_valid_q <= 1'b0;
    end else begin
      key_valid_q <= last_rx && op_class(op_q) == dpil_pkg::OP_KEY;
      if (state_q == dpil_pkg::ST_RXOP && rx_valid_i && op_class(op_q) == dpil_pkg::OP_KEY) begin
        key_q <= {rx_data_i, key_q[63:8]};
      end
    end
  end

  dpil_cs_regs #(
    .AW(AW)
  ) u_regs (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .dbg_we_i(cs_we),
    .dbg_addr_i(cur_op[3:0]),
    .dbg_wdata_i(rx_data_i),
    .dbg_rdata_o(cs_rdata),
    .status_i(status),
    .guard_val_o(guard_val),
    .gap_en_o(gap_en)
  );

  // guard time and interbyte gap are counted in bit ticks of the live baud
  dpil_tx_pacer u_pacer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .req_valid_i(state_q == dpil_pkg::ST_TX),
    .req_i(tx_req),
    .req_ready_o(pacer_ready),
    .bit_tick_i(bit_tick_i),
    .guard_bits_i(guard_bits(guard_val)),
    .gap_en_i(gap_en),
    .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i)
  );
endmodule

// ==== tb/dpil_core_props.sv ====
// checker on the dpil_core ports.
// assumes one clock domain; bound onto every dpil_core.
`timescale 1ns/1ps
module dpil_core_props (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic break_i,
  input wire logic rx_valid_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic mem_valid_o,
  input wire dpil_pkg::dpil_mem_req_s mem_req_o,
  input wire logic mem_ack_i,
  input wire logic key_valid_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wb ack too long");
  a_wb_answer_next: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("wb ack late");
  a_ack_char: assert property (mem_valid_o && mem_ack_i && mem_req_o.we |->
    ##[1:600] tx_valid_o && tx_data_o == dpil_pkg::ACK_CHAR) else $error("no ack char");
  a_write_from_rx: assert property ($rose(mem_valid_o) && mem_req_o.we |->
    $past(rx_valid_i) || $past(rx_valid_i, 2)) else $error("write without data");
  a_mem_req_hold: assert property (mem_valid_o && !mem_ack_i |=>
    mem_valid_o && $stable(mem_req_o)) else $error("bus request moved");
  a_mem_req_done: assert property (mem_valid_o && mem_ack_i |=> !mem_valid_o)
    else $error("bus request after ack");
  a_tx_byte_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("tx byte moved");
  a_key_no_reply: assert property (key_valid_o |=> (!tx_valid_o) [*8])
    else $error("reply after key");
  a_break_quiet: assert property (break_i |=> !mem_valid_o && !tx_valid_o)
    else $error("activity after break");
  c_bus_write: cover property (mem_valid_o && mem_ack_i && mem_req_o.we);
  c_key: cover property (key_valid_o);
  c_tx: cover property (tx_valid_o && tx_ready_i);
endmodule

bind dpil_core dpil_core_props u_props (.sys_clk_i, .reset_i, .break_i, .rx_valid_i,
  .tx_valid_o, .tx_data_o, .tx_ready_i, .mem_valid_o, .mem_req_o, .mem_ack_i,
  .key_valid_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ==== tb/dpil_bus_model.sv ====
// bus slave beside dpil_core: acks each request, reads give an address pattern.
// assumes requests stay up until ack; slow_i adds three wait cycles.
`timescale 1ns/1ps
module dpil_bus_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire dpil_pkg::dpil_mem_req_s req_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [1:0] wait_q;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {ack_o, wait_q, rdata_o} <= '0;
    end else begin
      ack_o <= 1'b0;
      // idle data keeps changing so a stale word never looks valid
      rdata_o <= ~rdata_o;
      if (valid_i && !ack_o && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (valid_i && !ack_o) begin
        ack_o <= 1'b1;
        rdata_o <= {8'hC3, req_i.addr[7:0] ^ 8'h5A};
        wait_q <= {2{slow_i}};
      end
    end
  end
endmodule

// ==== tb/dpil_core_test.sv ====
// self-checking bench for dpil_core: link bytes, bus writes, key, wishbone.
// assumes the bus model answers reads with a pattern made from the address.
`timescale 1ns/1ps
module dpil_core_test;
  localparam logic [127:0] SYSTEM_INFO_BLOCK = 128'h1F2E_3D4C_5B6A_7988_0112_2334_4556_6778; // arbitrary
  localparam logic [63:0] ACK = 64'h40;
  logic sys_clk_i = 0, reset_i = 1, sync_i = 0, break_i = 0, bit_tick_i = 0;
  logic rx_valid_i = 0, tx_ready_i = 0, slow = 0, mem_ack_i, tx_valid_o;
  logic mem_valid_o, key_valid_o, wb_ack_o;
  logic [7:0] rx_data_i = 8'h00, tx_data_o;
  logic [15:0] mem_rdata_i;
  logic [63:0] key_o;
  dpil_pkg::dpil_mem_req_s mem_req_o;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [63:0] txq[$], bq[$], kq[$], wq[$];
  int num_errors = 0, samples_checked = 0, seed = 73257;
  always #50 sys_clk_i = ~sys_clk_i;
  dpil_core #(.SIB_DATA(SYSTEM_INFO_BLOCK)) DUT (.*);
  dpil_bus_model u_bus (.sys_clk_i, .reset_i, .slow_i(slow), .valid_i(mem_valid_o),
    .req_i(mem_req_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  always @(posedge sys_clk_i) begin
    bit_tick_i <= ~bit_tick_i;
    tx_ready_i <= $random(seed);
    slow <= $random(seed);
  end
  task automatic cmp(string n, logic [63:0] e, logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge sys_clk_i) begin
    if (!reset_i && tx_valid_o && tx_ready_i)
      cmp("tx", txq.size() ? txq.pop_front() : 'x, tx_data_o);
    if (!reset_i && mem_valid_o && mem_ack_i && mem_req_o.we)
      cmp("bus", bq.size() ? bq.pop_front() : 'x, {mem_req_o.word, mem_req_o.addr,
        mem_req_o.word ? mem_req_o.wdata : {8'h00, mem_req_o.wdata[7:0]}});
    if (!reset_i && key_valid_o)
      cmp("key", kq.size() ? kq.pop_front() : 'x, key_o);
    if (!reset_i && wb_ack_o && !wb_we_i)
      cmp("wb", wq.size() ? wq.pop_front() : 'x, wb_dat_o);
  end
  task automatic send(int k, logic [7:0] b = 8'h00);
    @(posedge sys_clk_i);
    {sync_i, rx_valid_i, break_i} <= 3'b100 >> k;
    rx_data_i <= b;
    @(posedge sys_clk_i);
    {sync_i, rx_valid_i, break_i} <= 3'b000;
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && (txq.size() || bq.size()); i++) @(posedge sys_clk_i);
    repeat (20) @(posedge sys_clk_i);
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [7:0] d, logic [3:0] s = 4'hF);
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, a, s};
    wb_dat_i <= {24'($random(seed)), d};
    // hold until ack is sampled high; only the watchdog ends a hang
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(100 * 60000);
    num_errors++;
    test_done();
  end
  initial begin
    logic [7:0] a, d;
    logic [15:0] w;
    logic [63:0] kx;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 0;
    for (int i = 0; i < 4; i++) begin
      wq.push_back(64'h0);
      wb(0, i * 4, 8'h00);
    end
    wb(1, 8'h00, 8'hFF);
    wb(1, 8'h08, 8'h06);
    wb(1, 8'h40, 8'hFF);
    wq.push_back(64'h0);
    wb(0, 8'h40, 8'h00);
    wq.push_back(64'h0);
    wb(0, 8'h00, 8'h00);
    a = $random(seed);
    send(0);
    txq.push_back(ACK);
    send(1, 8'h68);
    send(1, a);
    drain();
    send(0);
    send(1, 8'hA0);
    send(1, 8'h02);
    send(0);
    send(1, 8'h64);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      bq.push_back({1'b0, 16'(a) + 16'(i), 16'(d)});
      txq.push_back(ACK);
      send(1, d);
      drain();
    end
    for (int j = 0; j < 2; j++) begin
      w = $random(seed);
      send(0);
      send(1, 8'h61);
      bq.push_back({1'b1, 16'(a) + 16'h3, w});
      txq.push_back(ACK);
      send(1, w[7:0]);
      send(1, w[15:8]);
      drain();
    end
    send(0);
    txq.push_back(64'((a + 8'h03) ^ 8'h5A));
    send(1, 8'h20);
    drain();
    wb(1, 8'h0C, 8'h01);
    send(0);
    send(1, 8'hC3);
    send(1, 8'h00);
    drain();
    send(0);
    txq.push_back(64'h0);
    send(1, 8'h83);
    drain();
    wb(1, 8'h08, 8'h01, 4'hE);
    wq.push_back(64'h6);
    wb(0, 8'h08, 8'h00, 4'h1);
    send(0);
    txq.push_back(64'h6);
    send(1, 8'h82);
    drain();
    wb(1, 8'h0C, 8'h01);
    send(0);
    for (int i = 0; i < 16; i++) txq.push_back(64'(SYSTEM_INFO_BLOCK[8*i+:8]));
    send(1, 8'hE5);
    drain();
    for (int i = 0; i < 8; i++) kx[8*i+:8] = $random(seed);
    kq.push_back(kx);
    send(0);
    send(1, 8'hE0);
    for (int i = 0; i < 8; i++) send(1, kx[8*i+:8]);
    drain();
    send(0);
    send(1, 8'hA0);
    send(1, 8'h05);
    send(0);
    send(1, 8'h64);
    d = $random(seed);
    bq.push_back({1'b0, 16'(a) + 16'h3, 16'(d)});
    txq.push_back(ACK);
    send(1, d);
    drain();
    send(2);
    w = 16'(a) + 16'h4;
    send(0);
    txq.push_back(64'(w[7:0]));
    txq.push_back(64'(w[15:8]));
    send(1, 8'h29);
    drain();
    send(0);
    txq.push_back(64'h1);
    send(1, 8'h83);
    drain();
    cmp("left", 64'h0, 64'(txq.size() + bq.size() + kq.size() + wq.size()));
    test_done();
  end
endmodule
